// [design/mtp_pkg.sv]
package mtp_pkg;

	// ==========================================
	// Address map in programming mode
	localparam logic [15:0] SEC_ADDR = 16'hffff;
	localparam logic [15:0] SEED0_ADDR = 16'hff7f;
	localparam logic [15:0] SEED1_ADDR = 16'hff3f;

	// ==========================================
	// Security register layout and values
	localparam int SEC_W = 3;
	localparam int LOCK_POS = 0;
	localparam int TRI_POS = 1;
	localparam int SEED_POS = 2;
	localparam logic [2:0] SEC_ERASED = 3'h7;
	localparam logic [4:0] SEC_PAD = 5'h1f;

	// ==========================================
	// Data values
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] LOCKED_DATA = 8'h00;
	localparam logic [7:0] RESET_DATA = 8'h00;

	// ==========================================
	// Decoded supply pin level
	localparam logic [1:0] VPP_LOGIC = 2'h0;
	localparam logic [1:0] VPP_PROG = 2'h1;
	localparam logic [1:0] VPP_ERASE = 2'h2;

	// ==========================================
	// Operations and erase sequencer states
	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_PROG, OP_PVER,
		OP_ERASE, OP_EVER, OP_ID, OP_INHIBIT
	} mtp_op_t;

	typedef enum logic {ST_IDLE, ST_ERASE} mtp_state_t;

endpackage : mtp_pkg

// [design/mtp_rom_program_access.sv]
// Overview of operation
// - Decode only with reset high, latch strobe low, store strobe high.
// - Read: lines low, select and enable low, logic supply: drive code byte.
// - With lock bit zero, reads return no valid code data.
// - Output enable high keeps the data bus undriven.
// - Program: programming supply, select low, enable high writes bus byte.
// - Program verify: programming supply, select high, enable low reads byte.
// - Erase: select line high, erase supply, address bit zero low, data FF.
// - Programming only clears bits; erase alone returns bits to one.
// - Erase verify: erase supply, select high, enable low reads stored byte.
// - Select and enable both high: program and erase are ignored.
// - Identification read: address bit zero picks maker or device code.
// - Security and ID registers reachable only in programming mode.
// - A cleared security bit stays cleared until full chip erase.
// - The security register sits at the top address of the space.
// - Lock bit zero blocks ROM data and special register access.
// - Table-read bit zero stops external code reading internal memory.
// - A seed other than FF scrambles read and verify data.
// - Seeds return to FF on erase; only erase disables scrambling.
// - Seeds are programmed like ROM bytes at their own addresses.
// - Seed bit zero refuses any access to both seeds.
`timescale 1ns/1ps

module mtp_rom_program_access import mtp_pkg::*; #(
	parameter int ROM_DEPTH = 32768,
	// Arbitrary identification values
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] DEVICE_CODE = 8'ha5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Mode qualifiers
	input wire logic reset_pin,
	input wire logic addr_latch_strobe,
	input wire logic program_store_strobe_n,
	// Mode control lines
	input wire logic id_erase_select_line,
	input wire logic upper_mode_line_b,
	input wire logic upper_mode_line_c,
	input wire logic output_mode_line,
	input wire logic chip_enable_n,
	input wire logic output_enable_n,
	input wire logic [1:0] vpp_level,
	// Address and data
	input wire logic [15:0] addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Table-read check from the core
	input wire logic fetch_external,
	input wire logic target_internal,
	output logic table_read_block,
	// Status
	output logic erase_busy,
	output logic lock_open,
	output logic encrypt_on
);

	localparam int AW = $clog2(ROM_DEPTH);
	localparam logic [AW-1:0] LAST_ADDR = AW'(ROM_DEPTH - 1);

	// ==========================================
	// Storage
	logic [7:0] rom_mem [ROM_DEPTH];
	logic [SEC_W-1:0] sec_r, sec_nxt;
	logic [7:0] seed0_r, seed0_nxt, seed1_r, seed1_nxt;
	mtp_state_t state_r, state_nxt;
	logic [AW-1:0] sweep_r, sweep_nxt;
	logic [7:0] data_out_r, data_out_nxt;
	logic data_oe_r, data_oe_nxt, block_r, block_nxt;
	logic rom_we;
	logic [AW-1:0] rom_wa;
	logic [7:0] rom_wd;
	mtp_op_t op;
	logic erase_go, in_rom, locked, enc;
	// Nonvolatile content known only after an erase
	logic nv_known_r, nv_known_nxt;

	function automatic mtp_op_t decode_op(input logic sel, input logic ce_n,
			input logic oe_n, input logic [1:0] vpp);
		mtp_op_t o;
		o = OP_NONE;
		if (ce_n && oe_n) begin
			o = OP_INHIBIT;
		end else if (!sel && !ce_n && !oe_n && vpp == VPP_LOGIC) begin
			o = OP_READ;
		end else if (!sel && !ce_n && oe_n && vpp == VPP_PROG) begin
			o = OP_PROG;
		end else if (!sel && ce_n && !oe_n && vpp == VPP_PROG) begin
			o = OP_PVER;
		end else if (sel && !ce_n && oe_n && vpp == VPP_ERASE) begin
			o = OP_ERASE;
		end else if (sel && ce_n && !oe_n && vpp == VPP_ERASE) begin
			o = OP_EVER;
		end else if (sel && !ce_n && !oe_n && vpp == VPP_LOGIC) begin
			o = OP_ID;
		end
		return o;
	endfunction : decode_op

	// Scrambling byte from both seeds and the address
	function automatic logic [7:0] key_byte(input logic [7:0] s0,
			input logic [7:0] s1, input logic [15:0] a);
		logic [7:0] x;
		x = s0 ^ {s1[3:0], s1[7:4]} ^ a[7:0] ^ a[15:8];
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : key_byte

	// ==========================================
	// Operation decode
	always_comb begin
		op = OP_NONE;
		if (reset_pin && !addr_latch_strobe && program_store_strobe_n &&
				!upper_mode_line_b && !upper_mode_line_c &&
				!output_mode_line) begin
			op = decode_op(id_erase_select_line, chip_enable_n,
				output_enable_n, vpp_level);
		end
	end

	assign in_rom = {16'h0, addr} < 32'(ROM_DEPTH);
	assign locked = !sec_r[LOCK_POS];
	assign enc = seed0_r != ERASED_BYTE || seed1_r != ERASED_BYTE;
	assign erase_go = op == OP_ERASE && state_r == ST_IDLE && !addr[0] &&
		data_in == ERASED_BYTE;

	// ==========================================
	// Erase sequencer and programming
	always_comb begin
		state_nxt = state_r;
		nv_known_nxt = nv_known_r || erase_go;
		sweep_nxt = sweep_r;
		sec_nxt = sec_r;
		seed0_nxt = seed0_r;
		seed1_nxt = seed1_r;
		rom_we = 1'b0;
		rom_wa = addr[AW-1:0];
		rom_wd = rom_mem[addr[AW-1:0]] & data_in;
		case (state_r)
			ST_IDLE: begin
				if (erase_go) begin
					state_nxt = ST_ERASE;
					sweep_nxt = '0;
					sec_nxt = SEC_ERASED;
					seed0_nxt = ERASED_BYTE;
					seed1_nxt = ERASED_BYTE;
				end else if (op == OP_PROG && !locked) begin
					if (in_rom) begin
						rom_we = 1'b1;
					end else if (addr == SEC_ADDR) begin
						sec_nxt = sec_r & data_in[SEC_W-1:0];
					end else if (sec_r[SEED_POS]) begin
						if (addr == SEED0_ADDR) begin
							seed0_nxt = seed0_r & data_in;
						end else if (addr == SEED1_ADDR) begin
							seed1_nxt = seed1_r & data_in;
						end
					end
				end
			end
			ST_ERASE: begin
				rom_we = 1'b1;
				rom_wa = sweep_r;
				rom_wd = ERASED_BYTE;
				sweep_nxt = sweep_r + AW'(1);
				if (sweep_r == LAST_ADDR) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			sweep_r <= '0;
			nv_known_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sweep_r <= sweep_nxt;
			nv_known_r <= nv_known_nxt;
		end
	end

	// Nonvolatile cells keep their content across reset
	always_ff @(posedge clk) begin
		sec_r <= sec_nxt;
		seed0_r <= seed0_nxt;
		seed1_r <= seed1_nxt;
		if (rom_we) begin
			rom_mem[rom_wa] <= rom_wd;
		end
	end

	// ==========================================
	// Read path
	always_comb begin
		data_oe_nxt = 1'b0;
		data_out_nxt = data_out_r;
		block_nxt = !sec_r[TRI_POS] && fetch_external &&
			target_internal;
		if (state_r == ST_IDLE && !output_enable_n &&
				(op == OP_READ || op == OP_PVER || op == OP_EVER ||
				op == OP_ID)) begin
			data_oe_nxt = 1'b1;
			if (locked) begin
				data_out_nxt = LOCKED_DATA;
			end else if (op == OP_ID) begin
				data_out_nxt = addr[0] ? DEVICE_CODE : MAKER_CODE;
			end else if (in_rom) begin
				data_out_nxt = rom_mem[addr[AW-1:0]];
				if (enc) begin
					data_out_nxt = data_out_nxt +
						key_byte(seed0_r, seed1_r, addr);
				end
			end else if (addr == SEC_ADDR) begin
				data_out_nxt = {SEC_PAD, sec_r};
			end else if (addr == SEED0_ADDR || addr == SEED1_ADDR) begin
				if (!sec_r[SEED_POS]) begin
					data_out_nxt = LOCKED_DATA;
				end else begin
					data_out_nxt = addr == SEED0_ADDR ? seed0_r : seed1_r;
				end
			end else begin
				data_out_nxt = ERASED_BYTE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_out_r <= RESET_DATA;
			data_oe_r <= 1'b0;
			block_r <= 1'b0;
			erase_busy <= 1'b0;
			lock_open <= 1'b0;
			encrypt_on <= 1'b0;
		end else begin
			data_out_r <= data_out_nxt;
			data_oe_r <= data_oe_nxt;
			block_r <= block_nxt;
			erase_busy <= state_nxt == ST_ERASE;
			lock_open <= sec_nxt[LOCK_POS];
			encrypt_on <= seed0_nxt != ERASED_BYTE ||
				seed1_nxt != ERASED_BYTE;
		end
	end

	assign data_out = data_out_r;
	assign data_oe = data_oe_r;
	assign table_read_block = block_r;

	// ==========================================
	// Checks
	sequence s_erase_start;
		erase_go;
	endsequence

	sequence s_erased_state;
		sec_r == SEC_ERASED && seed0_r == ERASED_BYTE &&
			seed1_r == ERASED_BYTE;
	endsequence

	a_oe_high_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		output_enable_n |=> !data_oe_r)
		else $error("Data bus driven with output enable high");

	a_mode_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!(reset_pin && !addr_latch_strobe && program_store_strobe_n)
		|=> !data_oe_r)
		else $error("Data driven outside programming mode");

	a_locked_read: assert property (@(posedge clk) disable iff (!rst_n)
		(op == OP_READ && locked && state_r == ST_IDLE)
		|=> data_oe_r && data_out_r == LOCKED_DATA)
		else $error("Locked device returned code data");

	a_sec_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(nv_known_r && !erase_go) |=> (sec_r & ~$past(sec_r)) == '0)
		else $error("Security bit returned to one without erase");

	a_encrypt_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(enc && !erase_go) |=> enc)
		else $error("Scrambling turned off without erase");

	a_erase_sets: assert property (@(posedge clk) disable iff (!rst_n)
		s_erase_start |=> s_erased_state ##0 erase_busy)
		else $error("Erase did not restore security and seeds");

	a_inhibit_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(nv_known_r && op == OP_INHIBIT && state_r == ST_IDLE)
		|=> $stable(sec_r) && $stable(seed0_r) && $stable(seed1_r))
		else $error("Inhibited device changed stored bits");

	a_id_maker: assert property (@(posedge clk) disable iff (!rst_n)
		(op == OP_ID && !locked && state_r == ST_IDLE && !addr[0])
		|=> data_oe_r && data_out_r == MAKER_CODE)
		else $error("Maker code not returned");

	a_seed_guard: assert property (@(posedge clk) disable iff (!rst_n)
		(op == OP_READ && !locked && !sec_r[SEED_POS] &&
		state_r == ST_IDLE && addr == SEED0_ADDR)
		|=> data_out_r == LOCKED_DATA)
		else $error("Seed byte readable with seed access cleared");

endmodule : mtp_rom_program_access

// [verification/mtp_prog_model.sv]
`timescale 1ns/1ps
// ==========================================
// Parallel programmer on the mode pins
module mtp_prog_model import mtp_pkg::*; (
	// Clock
	input wire logic clk,
	// Mode pins
	output logic reset_pin,
	output logic addr_latch_strobe,
	output logic program_store_strobe_n,
	output logic id_erase_select_line,
	output logic upper_mode_line_b,
	output logic upper_mode_line_c,
	output logic output_mode_line,
	output logic chip_enable_n,
	output logic output_enable_n,
	output logic [1:0] vpp_level,
	// Address and data
	output logic [15:0] addr,
	output logic [7:0] data_in
);
	initial begin
		reset_pin = 1'b1;
		addr_latch_strobe = 1'b0;
		program_store_strobe_n = 1'b1;
		{upper_mode_line_b, upper_mode_line_c, output_mode_line} = 3'h0;
		{id_erase_select_line, chip_enable_n, output_enable_n} = 3'h3;
		vpp_level = VPP_LOGIC;
		addr = 16'h0000;
		data_in = 8'h00;
	end
	// One cycle of select, chip select and enable
	task automatic op(input logic [2:0] c, input logic [1:0] v,
		input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		id_erase_select_line = c[2];
		chip_enable_n = c[1];
		output_enable_n = c[0];
		vpp_level = v;
		addr = a;
		// Released bus shows no stale byte
		data_in = c[0] ? d : ~data_in;
	endtask : op
	task automatic set_reset(input logic r);
		@(negedge clk);
		reset_pin = r;
	endtask : set_reset
endmodule : mtp_prog_model

// [verification/tb_mtp_rom_program_access.sv]
`timescale 1ns/1ps
module tb_mtp_rom_program_access import mtp_pkg::*;;
	typedef struct {
		logic [2:0] c;
		logic [1:0] v;
		logic [15:0] a;
		logic [7:0] d;
		logic oe;
		logic [7:0] q;
	} mtp_row_t;
	localparam logic [1:0] L = VPP_LOGIC, P = VPP_PROG, E = VPP_ERASE;
	localparam int DEPTH = 16;
	logic clk, rst_n, fetch_external, target_internal;
	logic reset_pin, ale, pss_n, sel, lb, lc, lo, ce_n, oe_n;
	logic [1:0] vpp;
	logic [15:0] addr;
	logic [7:0] data_in, data_out;
	logic data_oe, table_read_block, erase_busy, lock_open, encrypt_on;
	int fail_count = 0;
	int n_compared = 0;
	// Select/chip select/enable: 000 read, 001 program or off, 010 verify
	mtp_row_t rows [14] = '{
		'{3'h0, L, 16'h0003, 8'h00, 1'b1, 8'hff},
		'{3'h1, P, 16'h0003, 8'h3c, 1'b0, 8'h00},
		'{3'h2, P, 16'h0003, 8'h00, 1'b1, 8'h3c},
		'{3'h1, P, 16'h0003, 8'hf0, 1'b0, 8'h00},
		'{3'h6, E, 16'h0003, 8'h00, 1'b1, 8'h30},
		'{3'h3, P, 16'h0003, 8'h00, 1'b0, 8'h00},
		'{3'h7, E, 16'h0000, 8'hff, 1'b0, 8'h00},
		'{3'h0, L, 16'h0003, 8'h00, 1'b1, 8'h30},
		'{3'h4, L, 16'h0000, 8'h00, 1'b1, 8'h5a},
		'{3'h4, L, 16'h0001, 8'h00, 1'b1, 8'ha5},
		'{3'h0, L, 16'hffff, 8'h00, 1'b1, 8'hff},
		'{3'h1, L, 16'h0003, 8'h00, 1'b0, 8'h00},
		'{3'h1, P, 16'hffff, 8'hfd, 1'b0, 8'h00},
		'{3'h0, L, 16'hffff, 8'h00, 1'b1, 8'hfd}};

	mtp_prog_model i_prog (.clk(clk), .reset_pin(reset_pin),
		.addr_latch_strobe(ale), .program_store_strobe_n(pss_n),
		.id_erase_select_line(sel), .upper_mode_line_b(lb),
		.upper_mode_line_c(lc), .output_mode_line(lo),
		.chip_enable_n(ce_n), .output_enable_n(oe_n),
		.vpp_level(vpp), .addr(addr), .data_in(data_in));
	mtp_rom_program_access #(.ROM_DEPTH(DEPTH), .MAKER_CODE(8'h5a),
		.DEVICE_CODE(8'ha5)) i_dut (.clk(clk), .rst_n(rst_n),
		.reset_pin(reset_pin), .addr_latch_strobe(ale),
		.program_store_strobe_n(pss_n), .id_erase_select_line(sel),
		.upper_mode_line_b(lb), .upper_mode_line_c(lc),
		.output_mode_line(lo), .chip_enable_n(ce_n),
		.output_enable_n(oe_n), .vpp_level(vpp), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.fetch_external(fetch_external),
		.target_internal(target_internal),
		.table_read_block(table_read_block), .erase_busy(erase_busy),
		.lock_open(lock_open), .encrypt_on(encrypt_on));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic run(input logic [2:0] c, input logic [1:0] v,
		input logic [15:0] a, input logic [7:0] d);
		i_prog.op(c, v, a, d);
		@(posedge clk);
		#1;
	endtask : run
	task automatic erase_all;
		int n;
		int k;
		n = 0;
		run(3'h5, E, 16'h0000, 8'hff);
		chk("erase_busy", 8'h01, {7'h0, erase_busy});
		chk("encrypt_on", 8'h00, {7'h0, encrypt_on});
		run(3'h0, L, 16'h0003, 8'h00);
		chk("busy data_oe", 8'h00, {7'h0, data_oe});
		while (erase_busy !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (erase_busy !== 1'b0) begin
			fail_count++;
			wrap_up();
		end
		for (k = 0; k < DEPTH; k++) begin
			run(3'h6, E, 16'(k), 8'h00);
			chk("erase verify", ERASED_BYTE, data_out);
		end
	endtask : erase_all

	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		fetch_external = 1'b0;
		target_internal = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		erase_all();
		foreach (rows[i]) begin
			run(rows[i].c, rows[i].v, rows[i].a, rows[i].d);
			chk("data_oe", {7'h0, rows[i].oe}, {7'h0, data_oe});
			if (rows[i].oe)
				chk("data_out", rows[i].q, data_out);
		end
		$display("table rows done");
		@(negedge clk);
		{fetch_external, target_internal} = 2'h3;
		@(posedge clk);
		#1;
		chk("table_read_block", 8'h01, {7'h0, table_read_block});
		run(3'h1, P, 16'hffff, 8'hff);
		run(3'h0, L, 16'hffff, 8'h00);
		chk("sticky bit", 8'hfd, data_out);
		i_prog.set_reset(1'b0);
		run(3'h0, L, 16'h0003, 8'h00);
		chk("no mode data_oe", 8'h00, {7'h0, data_oe});
		i_prog.set_reset(1'b1);
		$display("qualifier test done");
		run(3'h1, P, 16'hff7f, 8'h12);
		run(3'h3, L, 16'h0000, 8'h00);
		chk("encrypt_on", 8'h01, {7'h0, encrypt_on});
		run(3'h0, L, 16'h0003, 8'h00);
		n_compared++;
		if (data_out === 8'h30 || $isunknown(data_out)) begin
			fail_count++;
			$display("unexpected scrambled read: expected not 30, seen %h",
				data_out);
		end
		erase_all();
		run(3'h0, L, 16'hffff, 8'h00);
		chk("erased sec", 8'hff, data_out);
		chk("table_read_block", 8'h00, {7'h0, table_read_block});
		run(3'h1, P, 16'hffff, 8'hfb);
		run(3'h1, P, 16'hff7f, 8'h00);
		run(3'h0, L, 16'hff7f, 8'h00);
		chk("seed read", 8'h00, data_out);
		chk("encrypt_on", 8'h00, {7'h0, encrypt_on});
		$display("seed test done");
		run(3'h1, P, 16'hffff, 8'hfe);
		run(3'h0, L, 16'h0003, 8'h00);
		chk("locked read", 8'h00, data_out);
		chk("lock_open", 8'h00, {7'h0, lock_open});
		run(3'h4, L, 16'h0001, 8'h00);
		chk("locked id", 8'h00, data_out);
		@(negedge clk);
		rst_n = 1'b0;
		@(posedge clk);
		#1;
		chk("reset data", 8'h00, data_out);
		chk("reset data_oe", 8'h00, {7'h0, data_oe});
		$display("lock and reset test done");
		wrap_up();
	end
endmodule : tb_mtp_rom_program_access
